// File: ueps_ep1_status.sv
/*
  Endpoint-1 halt-status register with its write protection, the automatic
  GET_STATUS answer, stall side effects, and the USB clock mask/select bits.
  Assumes the protocol engine decodes standard requests into one-cycle
  ueps_usb_req_t pulses on sys_clk, and that all inputs are sys_clk synchronous.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps

// Function
// - USB clock 48 MHz, internal x8 or external
// - GET_STATUS returns status register automatically
// - Status register writes accepted only when NAK-all set
// - Endpoint error sets halt flag
// - Status register writes ignored during bus-side endpoint access
// - Stall clears bulk-in buffer and NAK
module ueps_ep1_status (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire ueps_pkg::ueps_usb_req_t usb_req,
  input wire logic ep1_error,
  input wire logic ep1_bus_access,
  output ueps_pkg::ueps_status_resp_t status_resp,
  output logic ep1_bulk_in_clear,
  output logic bulk_in1_nak,
  input wire logic bulk_in1_nak_set,
  output logic ep0_nak_all,
  output logic [1:0] usb_clock_mask,
  output logic usb_clk_sel_ext,
  output logic ep1_halt_flag
);
  logic halt_reg, halt_next;
  logic nak_all_reg, nak_all_next;
  logic [1:0] mask_reg, mask_next;
  logic sel_reg, sel_next;
  logic [7:0] rdata_reg, rdata_next;
  ueps_pkg::ueps_status_resp_t resp_reg, resp_next;
  logic clr_reg, clr_next;
  logic nak_reg, nak_next;
  logic status_wr, ep1_stall_entry;
  logic hw_set, hw_clear;

  function automatic logic [7:0] status_byte(input logic h);
    status_byte = {7'h00, h};
  endfunction

  // Exact match of a register address
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // Halt flag: hardware set beats clear, clear beats software write
  always_comb begin
    hw_set = ep1_error
        || (usb_req.valid && usb_req.req == ueps_pkg::UEPS_REQ_SET_HALT);
    hw_clear = usb_req.valid && (usb_req.req == ueps_pkg::UEPS_REQ_CLR_HALT
        || usb_req.req == ueps_pkg::UEPS_REQ_SET_CONFIG
        || (usb_req.req == ueps_pkg::UEPS_REQ_SET_INTF && usb_req.intf_match));
    status_wr = wr_stb && addr_hit(addr, ueps_pkg::EP1_STATUS_ADDR)
                && nak_all_reg && !ep1_bus_access;
    halt_next = halt_reg;
    if (status_wr) begin
      halt_next = wdata[ueps_pkg::HALT_BIT];
    end
    if (hw_clear) begin
      halt_next = 1'b0;
    end
    if (hw_set) begin
      halt_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      halt_reg <= ueps_pkg::EP1_STATUS_RESET[ueps_pkg::HALT_BIT];
    end else begin
      halt_reg <= halt_next;
    end
  end

  // Stall side effects on every rise of the halt flag
  always_comb begin
    ep1_stall_entry = halt_next && !halt_reg;
    clr_next = ep1_stall_entry;
    nak_next = nak_reg;
    if (bulk_in1_nak_set) begin
      nak_next = 1'b1;
    end
    if (ep1_stall_entry) begin
      nak_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clr_reg <= 1'b0;
      nak_reg <= 1'b0;
    end else begin
      clr_reg <= clr_next;
      nak_reg <= nak_next;
    end
  end

  // Control and clock mask registers
  always_comb begin
    nak_all_next = nak_all_reg;
    mask_next = mask_reg;
    sel_next = sel_reg;
    if (wr_stb && addr_hit(addr, ueps_pkg::CTRL_ADDR)) begin
      nak_all_next = wdata[ueps_pkg::NAK_ALL_BIT];
      sel_next = wdata[ueps_pkg::CLK_SEL_BIT];
    end
    if (wr_stb && addr_hit(addr, ueps_pkg::CLK_MASK_ADDR)) begin
      mask_next = wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      nak_all_reg <= 1'b0;
      mask_reg <= ueps_pkg::CLK_MASK_RESET;
      sel_reg <= 1'b0;
    end else begin
      nak_all_reg <= nak_all_next;
      mask_reg <= mask_next;
      sel_reg <= sel_next;
    end
  end

  // GET_STATUS answer and register read data
  always_comb begin
    resp_next.valid = usb_req.valid && usb_req.req == ueps_pkg::UEPS_REQ_GET_STATUS;
    resp_next.data = status_byte(halt_reg);
    rdata_next = 8'h00;
    if (rd_stb) begin
      case (addr)
        ueps_pkg::EP1_STATUS_ADDR: rdata_next = status_byte(halt_reg);
        ueps_pkg::CLK_MASK_ADDR: rdata_next = {6'h00, mask_reg};
        ueps_pkg::CTRL_ADDR: rdata_next = {6'h00, sel_reg, nak_all_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
      resp_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
    end
  end

  assign rdata = rdata_reg;
  assign status_resp = resp_reg;
  assign ep1_bulk_in_clear = clr_reg;
  assign bulk_in1_nak = nak_reg;
  assign ep0_nak_all = nak_all_reg;
  assign usb_clock_mask = mask_reg;
  assign usb_clk_sel_ext = sel_reg;
  assign ep1_halt_flag = halt_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  wr_gate_a: assert property ((wr_stb && addr == ueps_pkg::EP1_STATUS_ADDR
      && !nak_all_reg && !ep1_error && !usb_req.valid) |=> $stable(halt_reg))
    else $error("status write taken without nak-all");
  wr_busy_a: assert property ((wr_stb && ep1_bus_access
      && !ep1_error && !usb_req.valid) |=> $stable(halt_reg))
    else $error("status write taken during bus access");
  err_halt_a: assert property (ep1_error |=> halt_reg)
    else $error("error did not set halt");
  get_status_a: assert property ((usb_req.valid
      && usb_req.req == ueps_pkg::UEPS_REQ_GET_STATUS)
      |=> status_resp.valid && status_resp.data == {7'h00, $past(halt_reg)})
    else $error("get status answer wrong");
  stall_side_a: assert property ($rose(halt_reg) |-> ep1_bulk_in_clear && !bulk_in1_nak)
    else $error("stall side effects missing");
  upper_zero_a: assert property (status_resp.data[7:1] == 7'h00)
    else $error("upper status bits not zero");
  clr_feat_a: assert property ((usb_req.valid
      && usb_req.req == ueps_pkg::UEPS_REQ_CLR_HALT && !ep1_error) |=> !halt_reg)
    else $error("clear feature kept halt");
  rd_back_a: assert property ((rd_stb && addr == ueps_pkg::EP1_STATUS_ADDR)
      |=> rdata == {7'h00, $past(halt_reg)})
    else $error("status readback wrong");
  mask_wr_a: assert property ((wr_stb && addr == ueps_pkg::CLK_MASK_ADDR)
      |=> usb_clock_mask == $past(wdata[1:0]))
    else $error("clock mask not written");
  clr_pulse_a: assert property (ep1_bulk_in_clear |=> !ep1_bulk_in_clear)
    else $error("bulk-in clear held too long");
  set_wins_a: assert property ((ep1_error && usb_req.valid
      && usb_req.req == ueps_pkg::UEPS_REQ_CLR_HALT) |=> halt_reg)
    else $error("clear beat hardware set");
  rd_idle_a: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data not zero outside read");
  nak_all_wr_a: assert property ((wr_stb && addr == ueps_pkg::CTRL_ADDR)
      |=> ep0_nak_all == $past(wdata[ueps_pkg::NAK_ALL_BIT]))
    else $error("nak-all bit not written");
  sel_wr_a: assert property ((wr_stb && addr == ueps_pkg::CTRL_ADDR)
      |=> usb_clk_sel_ext == $past(wdata[ueps_pkg::CLK_SEL_BIT]))
    else $error("clock select not written");
  resp_idle_a: assert property ((!usb_req.valid
      || usb_req.req != ueps_pkg::UEPS_REQ_GET_STATUS) |=> !status_resp.valid)
    else $error("status answer without request");

  cov_write_c: cover property (status_wr ##1 halt_reg);
  cov_stall_c: cover property ($rose(halt_reg) ##[1:8] status_resp.valid);
  cov_blocked_c: cover property (wr_stb && addr == ueps_pkg::EP1_STATUS_ADDR && ep1_bus_access);
  cov_halt_mask_c: cover property (usb_clock_mask == ueps_pkg::CLK_MASK_HALT);
  cov_set_wins_c: cover property (ep1_error && hw_clear);
endmodule // ueps_ep1_status

// File: ueps_pkg.sv
/*
  Package for the endpoint-1 halt-status block: register map, field layout,
  reset values, request decode codes and clock figures.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ueps_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] EP1_STATUS_ADDR = 32'h0020_0150;
  localparam logic [31:0] CLK_MASK_ADDR = 32'h0020_0154;
  localparam logic [31:0] CTRL_ADDR = 32'h0020_0158;
  localparam logic [7:0] EP1_STATUS_RESET = 8'h00;
  localparam logic [1:0] CLK_MASK_RESET = 2'h0;
  localparam logic [1:0] CLK_MASK_HALT = 2'h3;
  localparam int unsigned HALT_BIT = 0;
  localparam int unsigned NAK_ALL_BIT = 0;
  localparam int unsigned CLK_SEL_BIT = 1;
  localparam int unsigned USB_CLK_MHZ = 48;
  localparam int unsigned INT_SRC_MHZ = 6;
  localparam int unsigned PLL_MULT = USB_CLK_MHZ / INT_SRC_MHZ;

  typedef enum logic [2:0] {
    UEPS_REQ_NONE = 3'b000,
    UEPS_REQ_GET_STATUS = 3'b001,
    UEPS_REQ_SET_HALT = 3'b010,
    UEPS_REQ_CLR_HALT = 3'b011,
    UEPS_REQ_SET_CONFIG = 3'b100,
    UEPS_REQ_SET_INTF = 3'b101
  } ueps_req_t;

  typedef struct packed {
    logic valid;
    ueps_req_t req;
    logic intf_match;
  } ueps_usb_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ueps_status_resp_t;
endpackage

// File: ueps_host_model.sv
/* USB host side model: sends decoded standard requests to endpoint 1.
   Assumes the bench calls send right after a rising edge of sys_clk. */
`timescale 1ns/100ps
module ueps_host_model (
  input wire logic sys_clk,
  output ueps_pkg::ueps_usb_req_t usb_req
);
  initial usb_req = '0;
  // One-cycle request pulse
  task automatic send(ueps_pkg::ueps_req_t code, logic match);
    @(posedge sys_clk);
    usb_req <= '{1'b1, code, match};
    @(posedge sys_clk);
    usb_req <= '0;
  endtask
endmodule // ueps_host_model

// File: usb_ep1_halt_status_tb.sv
/* Self-checking bench for the endpoint-1 halt-status block.
   Assumes the host model drives usb_req and sys_clk runs at 40 MHz. */
`timescale 1ns/100ps
module usb_ep1_halt_status_tb;
  localparam logic [31:0] ST = ueps_pkg::EP1_STATUS_ADDR;
  localparam logic [31:0] CT = ueps_pkg::CTRL_ADDR;
  localparam int C[7] = '{2, 3, 2, 5, 5, 2, 4};
  localparam logic [6:0] EH = 7'b0101101;
  logic sys_clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, rd_d = 0;
  logic ep1_error = 0, ep1_bus_access = 0, bulk_in1_nak_set = 0;
  logic [31:0] addr = '0, seed = 32'h6;
  logic [7:0] wdata = '0, rdata, r;
  ueps_pkg::ueps_usb_req_t usb_req;
  ueps_pkg::ueps_status_resp_t status_resp;
  logic bulk_in1_nak, ep0_nak_all, usb_clk_sel_ext, ep1_halt_flag, ep1_bulk_in_clear;
  logic [1:0] usb_clock_mask;
  logic [7:0] exp_q[$];
  int miscompares = 0, samples_checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  ueps_ep1_status u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .usb_req(usb_req),
    .ep1_error(ep1_error), .ep1_bus_access(ep1_bus_access), .status_resp(status_resp),
    .ep1_bulk_in_clear(ep1_bulk_in_clear), .bulk_in1_nak(bulk_in1_nak),
    .bulk_in1_nak_set(bulk_in1_nak_set),
    .ep0_nak_all(ep0_nak_all), .usb_clock_mask(usb_clock_mask),
    .usb_clk_sel_ext(usb_clk_sel_ext), .ep1_halt_flag(ep1_halt_flag));
  ueps_host_model u_host (.sys_clk(sys_clk), .usb_req(usb_req));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [7:0] d);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [7:0] e);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read data and status answers are matched against the oldest note
  always @(posedge sys_clk) rd_d <= rd_stb;
  always @(negedge sys_clk) begin
    if (rd_d || status_resp.valid === 1'b1) begin
      check(rd_d ? rdata : status_resp.data, exp_q.pop_front());
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ST, 8'h00);
    wr(ST, rnd() | 8'h01);
    rd(ST, 8'h00);
    wr(CT, 8'h01);
    @(negedge sys_clk) check({7'h0, ep0_nak_all}, 8'h01);
    r = rnd();
    wr(ST, r);
    rd(ST, {7'h0, r[0]});
    wr(ST, 8'h01);
    ep1_bus_access <= 1'b1;
    wr(ST, 8'h00);
    ep1_bus_access <= 1'b0;
    rd(ST, 8'h01);
    exp_q.push_back(8'h01);
    u_host.send(ueps_pkg::UEPS_REQ_GET_STATUS, 1'b0);
    for (int i = 0; i < 7; i++) begin
      u_host.send(ueps_pkg::ueps_req_t'(C[i]), i == 4);
      rd(ST, {7'h0, EH[i]});
    end
    bulk_in1_nak_set <= 1'b1;
    @(posedge sys_clk);
    bulk_in1_nak_set <= 1'b0;
    @(negedge sys_clk) check({7'h0, bulk_in1_nak}, 8'h01);
    fork
      u_host.send(ueps_pkg::UEPS_REQ_CLR_HALT, 1'b0);
      begin
        @(posedge sys_clk) ep1_error <= 1'b1;
        @(posedge sys_clk) ep1_error <= 1'b0;
      end
    join
    @(negedge sys_clk) check({7'h0, ep1_halt_flag}, 8'h01);
    check({7'h0, bulk_in1_nak}, 8'h00);
    check({7'h0, ep1_bulk_in_clear}, 8'h01);
    wr(ueps_pkg::CLK_MASK_ADDR, 8'h03);
    wr(CT, 8'h03);
    @(negedge sys_clk) check({6'h0, usb_clock_mask}, 8'h03);
    check({7'h0, usb_clk_sel_ext}, 8'h01);
    rd(32'h0020_015c, 8'h00);
    repeat (3) @(posedge sys_clk);
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end
endmodule // usb_ep1_halt_status_tb
